// file: rtl/asu_pkg.sv
// Shared constants, types and helpers for the asynchronous serial unit
package asu_pkg;

  // Register byte offsets on the Avalon slave
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFS_STATUS   = 5'h00;
  localparam logic [4:0]  OFS_FRAME    = 5'h04;
  localparam logic [4:0]  OFS_ENIRQ    = 5'h08;
  localparam logic [4:0]  OFS_WIRE     = 5'h0c;
  localparam logic [4:0]  OFS_DATA     = 5'h10;
  localparam logic [4:0]  OFS_BAUD     = 5'h14;

  // Reset values
  localparam logic [7:0]  FRAME_RST    = 8'h00;
  localparam logic [7:0]  ENIRQ_RST    = 8'h00;
  localparam logic [7:0]  WIRE_RST     = 8'h00;
  localparam logic [7:0]  BAUD_RST     = 8'h00;

  // uart_status_flags fields
  localparam int ST_PARITY_ERROR_FLAG = 7;
  localparam int ST_NF   = 6;
  localparam int ST_FRAMING_ERROR_FLAG = 5;
  localparam int ST_OVERRUN_ERROR_FLAG = 4;
  localparam int ST_RIDL = 3;
  localparam int ST_RXRD = 2;
  localparam int ST_TIDL = 1;
  localparam int ST_TXEM = 0;

  // frame_control fields
  localparam int FC_UEN  = 7;
  localparam int FC_NINE = 6;
  localparam int FC_PEN  = 5;
  localparam int FC_PODD = 4;
  localparam int FC_STP2 = 3;
  localparam int FC_BRK  = 2;
  localparam int FC_RX9  = 1;
  localparam int FC_TX9  = 0;

  // enable_irq_control fields
  localparam int EC_TRANSMITTER_ENABLE = 7;
  localparam int EC_RECEIVER_ENABLE = 6;
  localparam int EC_HS   = 5;
  localparam int EC_ADEN = 4;
  localparam int EC_WAKE = 3;
  localparam int EC_RIE  = 2;
  localparam int EC_TX_IDLE_IRQ_ENABLE = 1;
  localparam int EC_TX_EMPTY_IRQ_ENABLE = 0;

  // wire_mode_control field
  localparam int WC_SWM  = 0;

  // Timing counts
  localparam logic [3:0]  OVS_LAST     = 4'hf;
  localparam logic [3:0]  SAMP_A       = 4'h7;
  localparam logic [3:0]  SAMP_B       = 4'h8;
  localparam logic [3:0]  SAMP_C       = 4'h9;
  localparam logic [3:0]  LAST_BIT8    = 4'h7;
  localparam logic [3:0]  LAST_BIT9    = 4'h8;
  localparam logic [3:0]  BRK_LAST     = 4'hc;
  localparam logic [1:0]  LS_PRE_LAST  = 2'h3;
  localparam int          RX_DEPTH     = 2;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_STOP  = 3'b011,
    TX_BREAK = 3'b100
  } asu_tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } asu_rx_state_e;

  typedef struct packed {
    logic [8:0] data;
    logic       parity_error_flag;
    logic       framing_error_flag;
    logic       nf;
  } asu_rx_word_s;

  // Parity over the data bits below the top position of the character
  function automatic logic asu_parity(input logic [8:0] d, input logic nine, input logic odd);
    asu_parity = (^d[6:0]) ^ (nine & d[7]) ^ odd;
  endfunction : asu_parity

  function automatic logic asu_top_bit(input logic [8:0] d, input logic nine);
    asu_top_bit = nine ? d[8] : d[7];
  endfunction : asu_top_bit

endpackage : asu_pkg

// file: rtl/asu_baud_gen.sv
// Baud rate generator producing the 16x oversampling tick
`timescale 1ns/1ps
`default_nettype none
module asu_baud_gen import asu_pkg::*; (
  // Clock and control
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       run,
  // Configuration
  input  wire logic       high_speed,
  input  wire logic [7:0] divisor,
  // Tick out
  output logic            tick
);

  logic [7:0] div_cnt_r;
  logic [1:0] pre_cnt_r;

  // Held in reset while the unit is off so a re-enable starts from a clean count
  always_ff @(posedge mclk) begin
    if (rst || (ce && !run)) begin
      div_cnt_r <= 8'h00;
      pre_cnt_r <= 2'h0;
      tick      <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (div_cnt_r == 8'h00) begin
        div_cnt_r <= divisor;
        if (high_speed || pre_cnt_r == LS_PRE_LAST) begin
          pre_cnt_r <= 2'h0;
          tick      <= 1'b1;
        end else begin
          pre_cnt_r <= pre_cnt_r + 2'h1;
        end
      end else begin
        div_cnt_r <= div_cnt_r - 8'h01;
      end
    end
  end

endmodule : asu_baud_gen
`default_nettype wire

// file: rtl/asu_uart.sv
// Asynchronous serial transmitter and receiver with Avalon-MM registers
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module asu_uart import asu_pkg::*; (
  // Clock, reset, clock enable
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Dedicated transmit pin
  output logic                   tx_o,
  output logic                   tx_oe,
  output logic                   tx_pull_dis,
  // Shared receive / transmit pin
  input  wire logic              rxtx_i,
  output logic                   rxtx_o,
  output logic                   rxtx_oe,
  output logic                   rxtx_pull_dis,
  // System requests
  output logic                   irq,
  output logic                   wake_req
);

  logic [7:0]    frame_r;
  logic [7:0]    enirq_r;
  logic          swm_r;
  logic [7:0]    baud_r;
  logic          acc;
  logic          wr_hit;
  logic          rd_hit;
  logic          data_rd;
  logic          data_acc;
  logic          err_clr;
  logic          status_seen_r;
  logic [7:0]    rd_mux;
  logic [7:0]    status;
  logic          unit_en;
  logic          nine;
  logic          tx_en_eff;
  logic          rx_en_eff;
  logic          tick;
  logic [3:0]    last_bit;
  logic [8:0]    hold_r;
  logic          hold_full_r;
  logic          tx_take;
  logic [8:0]    tx_load_vec;
  asu_tx_state_e tx_state_r;
  logic [3:0]    tx_tcnt_r;
  logic [3:0]    tx_bcnt_r;
  logic [8:0]    tx_shift_r;
  logic          tx_line_r;
  asu_rx_state_e rx_state_r;
  logic [3:0]    rx_tcnt_r;
  logic [3:0]    rx_bcnt_r;
  logic [8:0]    rx_shift_r;
  logic          rx_line;
  logic          s_a_r;
  logic          s_b_r;
  logic          maj;
  logic          noisy;
  logic          rx_noise_r;
  logic          rx_framing_error_flag_r;
  logic          rx_done_r;
  asu_rx_word_s  rx_word_r;
  asu_rx_word_s  fifo_mem [RX_DEPTH];
  logic          wr_ptr_r;
  logic          rd_ptr_r;
  logic [1:0]    count_r;
  logic          push;
  logic          pop;
  logic          overflow;
  logic          parity_error_flag_r;
  logic          nf_r;
  logic          framing_error_flag_r;
  logic          overrun_error_flag_r;
  logic          addr_hit_r;
  logic          tx_buffer_empty_flag;
  logic          transmitter_idle_flag;

  assign unit_en   = frame_r[FC_UEN];
  assign nine      = frame_r[FC_NINE];
  assign last_bit  = nine ? LAST_BIT9 : LAST_BIT8;
  assign tx_en_eff = unit_en & enirq_r[EC_TRANSMITTER_ENABLE] & ~(swm_r & enirq_r[EC_RECEIVER_ENABLE]);
  assign rx_en_eff = unit_en & enirq_r[EC_RECEIVER_ENABLE];

  // Bus handshake: waitrequest drops one cycle after the request, the access completes when it is low
  assign acc      = (avs_read | avs_write) & ~avs_waitrequest & ce;
  assign wr_hit   = acc & avs_write & avs_byteenable[0];
  assign rd_hit   = acc & avs_read;
  assign data_rd  = rd_hit & (avs_address == OFS_DATA);
  assign data_acc = (rd_hit | wr_hit) & (avs_address == OFS_DATA);
  assign err_clr  = data_acc & status_seen_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce) begin
      if (acc) begin
        avs_waitrequest <= 1'b1;
      end else if (avs_read || avs_write) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h00_0000, rd_mux};
      end
    end
  end

  assign tx_buffer_empty_flag  = ~hold_full_r;
  assign transmitter_idle_flag = ~hold_full_r & (tx_state_r == TX_IDLE) & ~frame_r[FC_BRK];
  assign status = {parity_error_flag_r, nf_r, framing_error_flag_r, overrun_error_flag_r, rx_state_r == RX_IDLE, count_r != 2'h0, transmitter_idle_flag, tx_buffer_empty_flag};

  always_comb begin
    if (avs_address == OFS_STATUS) begin
      rd_mux = status;
    end else if (avs_address == OFS_FRAME) begin
      rd_mux = {frame_r[7:2], fifo_mem[rd_ptr_r].data[8], 1'b0};
    end else if (avs_address == OFS_ENIRQ) begin
      rd_mux = enirq_r;
    end else if (avs_address == OFS_WIRE) begin
      rd_mux = {7'h00, swm_r};
    end else if (avs_address == OFS_DATA) begin
      rd_mux = fifo_mem[rd_ptr_r].data[7:0];
    end else if (avs_address == OFS_BAUD) begin
      rd_mux = baud_r;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Control registers; dropping the unit enable also drops both direction enables and break
  always_ff @(posedge mclk) begin
    if (rst) begin
      frame_r <= FRAME_RST;
      enirq_r <= ENIRQ_RST;
      swm_r   <= WIRE_RST[WC_SWM];
      baud_r  <= BAUD_RST;
    end else if (ce) begin
      if (wr_hit && avs_address == OFS_FRAME) begin
        frame_r <= {avs_writedata[7:2], 1'b0, avs_writedata[FC_TX9]};
        if (!avs_writedata[FC_UEN]) begin
          frame_r[FC_BRK] <= 1'b0;
          enirq_r[EC_TRANSMITTER_ENABLE] <= 1'b0;
          enirq_r[EC_RECEIVER_ENABLE] <= 1'b0;
        end
      end else if (wr_hit && avs_address == OFS_ENIRQ) begin
        enirq_r <= avs_writedata[7:0];
      end else if (wr_hit && avs_address == OFS_WIRE) begin
        swm_r <= avs_writedata[WC_SWM];
      end else if (wr_hit && avs_address == OFS_BAUD) begin
        baud_r <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_seen_r <= 1'b0;
    end else if (ce) begin
      if (rd_hit && avs_address == OFS_STATUS) begin
        status_seen_r <= 1'b1;
      end else if (data_acc) begin
        status_seen_r <= 1'b0;
      end
    end
  end

  asu_baud_gen u_baud (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .run        (unit_en),
    .high_speed (enirq_r[EC_HS]),
    .divisor    (baud_r),
    .tick       (tick)
  );

  // Transmit holding register; a write while it is still full is dropped
  assign tx_take = ce & tx_en_eff & hold_full_r & (tx_state_r == TX_IDLE);

  always_ff @(posedge mclk) begin
    if (rst || (ce && !tx_en_eff)) begin
      hold_r      <= 9'h000;
      hold_full_r <= 1'b0;
    end else if (ce) begin
      if (tx_take) begin
        hold_full_r <= 1'b0;
      end else if (wr_hit && avs_address == OFS_DATA && !hold_full_r) begin
        hold_r      <= {frame_r[FC_TX9], avs_writedata[7:0]};
        hold_full_r <= 1'b1;
      end
    end
  end

  always_comb begin
    tx_load_vec = hold_r;
    if (!nine) begin
      tx_load_vec[8] = 1'b0;
    end
    if (frame_r[FC_PEN]) begin
      tx_load_vec[last_bit] = asu_parity(hold_r, nine, frame_r[FC_PODD]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || (ce && !tx_en_eff)) begin
      tx_state_r <= TX_IDLE;
      tx_tcnt_r  <= 4'h0;
      tx_bcnt_r  <= 4'h0;
      tx_shift_r <= 9'h000;
      tx_line_r  <= 1'b1;
    end else if (ce) begin
      case (tx_state_r)
        TX_IDLE: begin
          tx_tcnt_r <= 4'h0;
          tx_bcnt_r <= 4'h0;
          if (hold_full_r) begin
            tx_shift_r <= tx_load_vec;
            tx_line_r  <= 1'b0;
            tx_state_r <= TX_START;
          end else if (frame_r[FC_BRK]) begin
            tx_line_r  <= 1'b0;
            tx_state_r <= TX_BREAK;
          end else begin
            tx_line_r <= 1'b1;
          end
        end
        default: begin
          if (tick) begin
            tx_tcnt_r <= tx_tcnt_r + 4'h1;
            if (tx_tcnt_r == OVS_LAST) begin
              case (tx_state_r)
                TX_START: begin
                  tx_line_r  <= tx_shift_r[0];
                  tx_state_r <= TX_DATA;
                end
                TX_DATA: begin
                  if (tx_bcnt_r == last_bit) begin
                    tx_line_r  <= 1'b1;
                    tx_bcnt_r  <= 4'h0;
                    tx_state_r <= TX_STOP;
                  end else begin
                    tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                    tx_line_r  <= tx_shift_r[1];
                    tx_bcnt_r  <= tx_bcnt_r + 4'h1;
                  end
                end
                TX_STOP: begin
                  if (frame_r[FC_STP2] && tx_bcnt_r == 4'h0) begin
                    tx_bcnt_r <= 4'h1;
                  end else begin
                    tx_state_r <= TX_IDLE;
                  end
                end
                default: begin
                  // Break holds the line low at least thirteen bit times
                  if (tx_bcnt_r != BRK_LAST) begin
                    tx_bcnt_r <= tx_bcnt_r + 4'h1;
                  end else if (!frame_r[FC_BRK]) begin
                    tx_line_r  <= 1'b1;
                    tx_state_r <= TX_IDLE;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // Receiver: majority of three samples mid-bit, disagreement marks noise
  assign rx_line = rx_en_eff ? rxtx_i : 1'b1;
  assign maj     = (s_a_r & s_b_r) | (s_a_r & rx_line) | (s_b_r & rx_line);
  assign noisy   = ~((s_a_r == s_b_r) & (s_b_r == rx_line));

  always_ff @(posedge mclk) begin
    if (rst || (ce && !rx_en_eff)) begin
      rx_state_r <= RX_IDLE;
      rx_tcnt_r  <= 4'h0;
      rx_bcnt_r  <= 4'h0;
      rx_shift_r <= 9'h000;
      s_a_r      <= 1'b1;
      s_b_r      <= 1'b1;
      rx_noise_r <= 1'b0;
      rx_framing_error_flag_r  <= 1'b0;
      rx_done_r  <= 1'b0;
      rx_word_r  <= '0;
    end else if (ce) begin
      rx_done_r <= 1'b0;
      if (rx_state_r == RX_IDLE) begin
        rx_tcnt_r <= 4'h0;
        rx_bcnt_r <= 4'h0;
        if (!rx_line) begin
          rx_shift_r <= 9'h000;
          rx_noise_r <= 1'b0;
          rx_framing_error_flag_r  <= 1'b0;
          rx_state_r <= RX_START;
        end
      end else if (tick) begin
        rx_tcnt_r <= rx_tcnt_r + 4'h1;
        if (rx_tcnt_r == SAMP_A) begin
          s_a_r <= rx_line;
        end
        if (rx_tcnt_r == SAMP_B) begin
          s_b_r <= rx_line;
        end
        if (rx_tcnt_r == SAMP_C) begin
          rx_noise_r <= rx_noise_r | noisy;
          case (rx_state_r)
            RX_START: begin
              if (maj) begin
                rx_state_r <= RX_IDLE;
              end
            end
            RX_DATA: begin
              rx_shift_r[rx_bcnt_r] <= maj;
            end
            default: begin
              rx_framing_error_flag_r <= rx_framing_error_flag_r | ~maj;
              if (!frame_r[FC_STP2] || rx_bcnt_r == 4'h1) begin
                rx_done_r      <= 1'b1;
                rx_word_r.data <= rx_shift_r;
                rx_word_r.framing_error_flag <= rx_framing_error_flag_r | ~maj;
                rx_word_r.nf   <= rx_noise_r | noisy;
                rx_word_r.parity_error_flag <= frame_r[FC_PEN] &
                                  (asu_parity(rx_shift_r, nine, frame_r[FC_PODD]) !=
                                   asu_top_bit(rx_shift_r, nine));
                rx_state_r     <= RX_IDLE;
              end
            end
          endcase
        end
        if (rx_tcnt_r == OVS_LAST) begin
          if (rx_state_r == RX_START) begin
            rx_state_r <= RX_DATA;
          end else if (rx_state_r == RX_DATA) begin
            if (rx_bcnt_r == last_bit) begin
              rx_bcnt_r  <= 4'h0;
              rx_state_r <= RX_STOP;
            end else begin
              rx_bcnt_r <= rx_bcnt_r + 4'h1;
            end
          end else if (rx_state_r == RX_STOP) begin
            rx_bcnt_r <= rx_bcnt_r + 4'h1;
          end
        end
      end
    end
  end

  // Receive FIFO; while overrun stands no new character is stored
  assign push     = ce & rx_done_r & ~overrun_error_flag_r & (count_r != 2'h2);
  assign overflow = ce & rx_done_r & (overrun_error_flag_r | (count_r == 2'h2));
  assign pop      = data_rd & (count_r != 2'h0);

  always_ff @(posedge mclk) begin
    if (rst || (ce && !unit_en)) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
      // Entries cleared so reading an empty buffer never returns unknowns
      for (int i = 0; i < RX_DEPTH; i++) begin
        fifo_mem[i] <= '0;
      end
    end else if (ce) begin
      if (push) begin
        fifo_mem[wr_ptr_r] <= rx_word_r;
        wr_ptr_r           <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Error flags: an event in the clearing cycle wins over the clear
  always_ff @(posedge mclk) begin
    if (rst || (ce && !unit_en)) begin
      parity_error_flag_r     <= 1'b0;
      nf_r       <= 1'b0;
      framing_error_flag_r     <= 1'b0;
      overrun_error_flag_r     <= 1'b0;
      addr_hit_r <= 1'b0;
    end else if (ce) begin
      parity_error_flag_r     <= (parity_error_flag_r & ~err_clr) | (push & rx_word_r.parity_error_flag);
      nf_r       <= (nf_r & ~err_clr) | (push & rx_word_r.nf);
      framing_error_flag_r     <= (framing_error_flag_r & ~err_clr) | (push & rx_word_r.framing_error_flag);
      overrun_error_flag_r     <= (overrun_error_flag_r & ~err_clr) | overflow;
      addr_hit_r <= (addr_hit_r & ~data_rd) |
                    (push & enirq_r[EC_ADEN] & asu_top_bit(rx_word_r.data, nine));
    end
  end

  // Pins and requests, all registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_o          <= 1'b1;
      tx_oe         <= 1'b0;
      tx_pull_dis   <= 1'b0;
      rxtx_o        <= 1'b1;
      rxtx_oe       <= 1'b0;
      rxtx_pull_dis <= 1'b0;
      irq           <= 1'b0;
      wake_req      <= 1'b0;
    end else if (ce) begin
      tx_o          <= tx_line_r;
      tx_oe         <= tx_en_eff;
      tx_pull_dis   <= tx_en_eff;
      rxtx_o        <= swm_r ? tx_line_r : 1'b1;
      rxtx_oe       <= swm_r & tx_en_eff;
      rxtx_pull_dis <= rx_en_eff | (swm_r & tx_en_eff);
      irq           <= (enirq_r[EC_RIE] & ((count_r != 2'h0) | overrun_error_flag_r)) |
                       (enirq_r[EC_TX_IDLE_IRQ_ENABLE] & transmitter_idle_flag) | (enirq_r[EC_TX_EMPTY_IRQ_ENABLE] & tx_buffer_empty_flag) | addr_hit_r;
      wake_req      <= unit_en & enirq_r[EC_WAKE] & ~rxtx_i;
    end
  end

endmodule : asu_uart
`default_nettype wire

// file: tb/asu_uart_asserts.sv
// Port checks for the serial unit
`timescale 1ns/1ps
`default_nettype none
module asu_uart_asserts import asu_pkg::*; (
  // Clock and bus
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins
  input wire logic        tx_o,
  input wire logic        tx_oe,
  input wire logic        tx_pull_dis,
  input wire logic        rxtx_i,
  input wire logic        rxtx_o,
  input wire logic        rxtx_oe,
  input wire logic        rxtx_pull_dis,
  input wire logic        wake_req
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus not answered");
  rdata_hold_a: assert property (avs_waitrequest && !avs_read && !avs_write |=> $stable(avs_readdata))
    else $error("readdata moved");
  start_len_a: assert property ($fell(tx_o) |-> ##15 !tx_o)
    else $error("low bit short");
  high_len_a: assert property ($rose(tx_o) |-> tx_o[*8] ##8 tx_o)
    else $error("high bit short");
  tx_pull_a: assert property (tx_oe |-> tx_pull_dis)
    else $error("tx pull kept");
  rxtx_pull_a: assert property ($rose(rxtx_oe) |-> rxtx_pull_dis)
    else $error("rxtx pull kept");
  both_pins_a: assert property (rxtx_oe && tx_oe |-> rxtx_o == tx_o)
    else $error("pins differ");
  wake_cause_a: assert property (wake_req |-> $past(rxtx_i) == 1'b0)
    else $error("wake without low");
endmodule : asu_uart_asserts
bind asu_uart asu_uart_asserts chk_u (.mclk, .rst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .tx_o, .tx_oe, .tx_pull_dis, .rxtx_i, .rxtx_o, .rxtx_oe, .rxtx_pull_dis, .wake_req);
`default_nettype wire

// file: tb/asu_serial_peer.sv
// Far-side serial device on the shared pin
`timescale 1ns/1ps
`default_nettype none
module asu_serial_peer (
  // Clock and line
  input  wire logic mclk,
  output logic      line
);
  // Released line rests at the pull-up level
  initial line = 1'b1;
  // n bits LSB first, 16 clocks each
  task automatic send(input logic [10:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      line <= b[i];
      repeat (15) @(posedge mclk);
    end
    @(posedge mclk);
    line <= 1'b1;
  endtask : send
endmodule : asu_serial_peer
`default_nettype wire

// file: tb/asu_uart_bench.sv
// Self-checking bench for the serial unit
`timescale 1ns/1ps
`default_nettype none
module asu_uart_bench import asu_pkg::*; ;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        tx_o, tx_oe, rxtx_o, rxtx_oe, peer_line, irq;
  wire         rxtx_line;
  int          n_errors, checked, cyc;
  logic [7:0]  q;
  // Wire level from both drivers
  assign rxtx_line = rxtx_oe ? rxtx_o : peer_line;
  always #2.5 mclk = !mclk;
  asu_uart dut_u (.mclk, .rst, .ce(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .tx_o, .tx_oe, .tx_pull_dis(),
    .rxtx_i(rxtx_line), .rxtx_o, .rxtx_oe, .rxtx_pull_dis(), .irq, .wake_req());
  asu_serial_peer peer_u (.mclk, .line(peer_line));
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rdc
  // Odd parity in the top data position, two stop bits
  function automatic logic [10:0] fr(input logic [7:0] d, input logic bad);
    fr = {2'b11, ^d[6:0] ^ 1'b1 ^ bad, d[6:0], 1'b0};
  endfunction : fr
  task automatic t_regs();
    rdc(OFS_STATUS, 8'h0B);
    rdc(OFS_FRAME, FRAME_RST);
    bus(1'b1, OFS_STATUS, 8'hff);
    rdc(OFS_STATUS, 8'h0B);
    bus(1'b1, OFS_WIRE, 8'hff);
    rdc(OFS_WIRE, 8'h01);
    bus(1'b1, OFS_BAUD, 8'h5a);
    rdc(OFS_BAUD, 8'h5a);
    rdc(5'h18, 8'h00);
    bus(1'b1, OFS_BAUD, 8'h00);
    bus(1'b1, OFS_WIRE, 8'h00);
  endtask : t_regs
  task automatic t_tx(input logic [7:0] d, input logic [10:0] e);
    bus(1'b1, OFS_DATA, d);
    for (int i = 0; i < 400 && tx_o !== 1'b0; i++) @(posedge mclk);
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 11; i++) begin
      chk({7'h00, tx_o}, {7'h00, e[i]});
      repeat (16) @(posedge mclk);
    end
  endtask : t_tx
  task automatic t_irq();
    bus(1'b1, OFS_ENIRQ, 8'ha1);
    repeat (2) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, OFS_ENIRQ, 8'ha0);
    repeat (2) @(posedge mclk);
    chk({7'h00, irq}, 8'h00);
  endtask : t_irq
  task automatic t_swm();
    bus(1'b1, OFS_WIRE, 8'h01);
    t_tx(8'h5c, fr(8'h5c, 1'b0));
    chk({7'h00, rxtx_oe}, 8'h01);
    bus(1'b1, OFS_ENIRQ, 8'he0);
    repeat (4) @(posedge mclk);
    chk({7'h00, rxtx_oe}, 8'h00);
    bus(1'b1, OFS_WIRE, 8'h00);
  endtask : t_swm
  task automatic t_rx();
    bus(1'b1, OFS_ENIRQ, 8'h78);
    peer_u.send(fr(8'h3c, 1'b0), 11);
    peer_u.send(fr(8'h55, 1'b1), 11);
    peer_u.send(fr(8'h0f, 1'b0), 11);
    repeat (8) @(posedge mclk);
    rdc(OFS_STATUS, 8'h9F);
    chk({7'h00, irq}, 8'h01);
    bus(1'b0, OFS_DATA, 8'h00);
    chk(q & 8'h7f, 8'h3c);
    rdc(OFS_STATUS, 8'h0F);
    chk({7'h00, irq}, 8'h00);
    bus(1'b0, OFS_DATA, 8'h00);
    chk(q & 8'h7f, 8'h55);
    rdc(OFS_STATUS, 8'h0B);
    peer_u.send(fr(8'h11, 1'b0) & 11'h5ff, 11);
    repeat (8) @(posedge mclk);
    rdc(OFS_STATUS, 8'h2F);
    bus(1'b1, OFS_FRAME, 8'h38);
    rdc(OFS_ENIRQ, 8'h38);
    rdc(OFS_STATUS, 8'h0B);
  endtask : t_rx
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    bus(1'b1, OFS_FRAME, 8'hb8);
    bus(1'b1, OFS_ENIRQ, 8'ha0);
    t_irq();
    t_tx(8'h35, fr(8'h35, 1'b0));
    t_tx(8'hca, fr(8'hca, 1'b0));
    bus(1'b1, OFS_FRAME, 8'hc0);
    t_tx(8'h5a, {2'b10, 8'h5a, 1'b0});
    bus(1'b1, OFS_FRAME, 8'hb8);
    t_swm();
    t_rx();
    results();
  end
endmodule : asu_uart_bench
`default_nettype wire
